// ### gyn_nvm_image.sv
`timescale 1ns/10ps

// Operation
// - Backup interface config and four offset bytes
// - Store reached only through image registers
// - Reset copies stored contents into images
// - Ready bit low while image load runs
// - Images read and written like other registers
// - Program command starts writing the store
// - Every program rewrites all store locations
// - Ready low during program, high after
module gyn_nvm_image #(
  parameter int PROGRAM_CYCLES = gyn_pkg::PROGRAM_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire gyn_pkg::gyn_req_type    request,
  output logic [7:0]                   readData,
  output logic                         nvmReady,
  output logic                         powerNormal,
  output logic [7:0]                   interfaceConfig,
  output gyn_pkg::gyn_offset_type      offsetComp
);

  localparam int IMAGE_COUNT = gyn_pkg::IMAGE_COUNT;
  localparam int IDX_W       = gyn_pkg::IMAGE_IDX_W;
  localparam int PROG_W      = gyn_pkg::PROG_COUNT_W;

  // Slot numbers of the five images, in load order
  localparam logic [IDX_W-1:0] SLOT_IF_CFG = IDX_W'(0);
  localparam logic [IDX_W-1:0] SLOT_X_LOW  = IDX_W'(1);
  localparam logic [IDX_W-1:0] SLOT_Y_LOW  = IDX_W'(2);
  localparam logic [IDX_W-1:0] SLOT_Z_LOW  = IDX_W'(3);
  localparam logic [IDX_W-1:0] SLOT_HIGH   = IDX_W'(4);

  // Final count of a program; the cells take the images on it
  localparam logic [PROG_W-1:0] PROG_LAST = PROG_W'(PROGRAM_CYCLES - 1);

  // Non-volatile cells: never touched by rst, so contents survive resets
  logic [7:0]                 storeCell [IMAGE_COUNT] = '{default: 8'h00};
  logic [7:0]                 image     [IMAGE_COUNT];
  logic [7:0]                 miscConfig;
  gyn_pkg::gyn_state_type     state;
  logic [IDX_W-1:0]           loadIndex;
  logic [PROG_W-1:0]          progCount;
  logic                       hitImage;
  logic [IDX_W-1:0]           hitIndex;
  logic                       cmdWrite;
  logic                       startProgram;
  logic                       progDone;

  // Map an address onto an image slot
  function automatic logic [IDX_W:0] image_slot(input logic [7:0] addr);
    logic [IDX_W:0] slot;
    slot = '0;
    case (addr)
      gyn_pkg::ADDR_NV_IF_CFG:   slot = {1'b1, SLOT_IF_CFG};
      gyn_pkg::ADDR_OFF_X_LOW:   slot = {1'b1, SLOT_X_LOW};
      gyn_pkg::ADDR_OFF_Y_LOW:   slot = {1'b1, SLOT_Y_LOW};
      gyn_pkg::ADDR_OFF_Z_LOW:   slot = {1'b1, SLOT_Z_LOW};
      gyn_pkg::ADDR_OFF_HIGH_EN: slot = {1'b1, SLOT_HIGH};
      default:                   slot = '0;
    endcase
    return slot;
  endfunction : image_slot

  // Writable bits of each slot, reserved ones forced to zero
  function automatic logic [7:0] slot_mask(input logic [IDX_W-1:0] idx);
    logic [7:0] mask;
    mask = gyn_pkg::MASK_OFF_LOW;
    case (idx)
      SLOT_IF_CFG: mask = gyn_pkg::MASK_NV_IF_CFG;
      SLOT_HIGH:   mask = gyn_pkg::MASK_OFF_HIGH_EN;
      default: mask = gyn_pkg::MASK_OFF_LOW;
    endcase
    return mask;
  endfunction : slot_mask

  // Access decode
  assign hitImage = image_slot(request.addr)[IDX_W];
  assign hitIndex = image_slot(request.addr)[IDX_W-1:0];
  assign cmdWrite = request.wr && (request.addr == gyn_pkg::ADDR_COMMAND);
  assign progDone = (state == gyn_pkg::ST_PROGRAM)
                    && (progCount == PROG_LAST);

  // Only an unlocked, idle, normal-power device starts a store write
  assign startProgram = cmdWrite
                        && (request.wdata == gyn_pkg::CMD_PROGRAM)
                        && miscConfig[gyn_pkg::MISC_PROG_UNLOCK_BIT]
                        && powerNormal
                        && (state == gyn_pkg::ST_IDLE);

  // Sequencer: load after every reset, then idle until a program
  // Programs are not counted; the host keeps within the wear limit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= gyn_pkg::ST_LOAD;
    end
    else
    begin
      case (state)
        gyn_pkg::ST_LOAD:
        begin
          if (loadIndex == IDX_W'(IMAGE_COUNT - 1))
          begin
            state <= gyn_pkg::ST_IDLE;
          end
        end
        gyn_pkg::ST_IDLE:
        begin
          if (startProgram)
          begin
            state <= gyn_pkg::ST_PROGRAM;
          end
        end
        gyn_pkg::ST_PROGRAM:
        begin
          if (progDone)
          begin
            state <= gyn_pkg::ST_IDLE;
          end
        end
        default:
        begin
          state <= gyn_pkg::ST_LOAD;
        end
      endcase
    end
  end

  // Load walks the slots one per cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      loadIndex <= '0;
    end
    else if (state == gyn_pkg::ST_LOAD)
    begin
      loadIndex <= loadIndex + IDX_W'(1);
    end
    else
    begin
      loadIndex <= '0;
    end
  end

  // Cell write time; cleared whenever not programming
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      progCount <= '0;
    end
    else if (state == gyn_pkg::ST_PROGRAM)
    begin
      progCount <= progCount + PROG_W'(1);
    end
    else
    begin
      progCount <= '0;
    end
  end

  // Whole store written at once at the end; images are frozen meanwhile
  // Reset leaves the cells alone, so a finished program outlives it
  always_ff @(posedge clk)
  begin
    if (progDone)
    begin
      for (int i = 0; i < IMAGE_COUNT; i++)
      begin
        storeCell[i] <= image[i];
      end
    end
  end

  // Image registers: filled by load, otherwise host writable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < IMAGE_COUNT; i++)
      begin
        image[i] <= gyn_pkg::RESET_IMAGE;
      end
    end
    else if (state == gyn_pkg::ST_LOAD)
    begin
      image[loadIndex] <= storeCell[loadIndex];
    end
    else if (request.wr && hitImage && (state == gyn_pkg::ST_IDLE))
    begin
      // Writes during a program are dropped to keep store and image equal
      image[hitIndex] <= request.wdata & slot_mask(hitIndex);
    end
  end

  // Unlock bit, host controlled
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      miscConfig <= gyn_pkg::RESET_MISC_CONFIG;
    end
    else if (request.wr && (request.addr == gyn_pkg::ADDR_MISC_CONFIG))
    begin
      miscConfig <= request.wdata & gyn_pkg::MASK_MISC_CONFIG;
    end
  end

  // Power state; a change is refused while the store is busy
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      powerNormal <= 1'b0;
    end
    else if (cmdWrite && (state == gyn_pkg::ST_IDLE))
    begin
      if (request.wdata == gyn_pkg::CMD_NORMAL)
      begin
        powerNormal <= 1'b1;
      end
      else if (request.wdata == gyn_pkg::CMD_SUSPEND)
      begin
        powerNormal <= 1'b0;
      end
    end
  end

  // Ready flag low during load and program
  // Falls on the edge that accepts a program, so no ready gap
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      nvmReady <= 1'b0;
    end
    else
    begin
      nvmReady <= (state == gyn_pkg::ST_IDLE) && !startProgram;
    end
  end

  // Read data, one cycle after the read request
  // Status carries only the ready bit; other bits read zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      readData <= gyn_pkg::RESET_READ_DATA;
    end
    else if (request.rd)
    begin
      if (hitImage)
      begin
        readData <= image[hitIndex];
      end
      else if (request.addr == gyn_pkg::ADDR_MISC_CONFIG)
      begin
        readData <= miscConfig;
      end
      else if (request.addr == gyn_pkg::ADDR_STATUS)
      begin
        readData <= 8'(nvmReady) << gyn_pkg::STATUS_NVM_READY_BIT;
      end
      else
      begin
        readData <= 8'h00;
      end
    end
  end

  // Images drive the interface and offset datapath
  // Ten-bit offsets: low byte plus two bits of the shared high byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      interfaceConfig <= gyn_pkg::RESET_IMAGE;
      offsetComp      <= '0;
    end
    else
    begin
      interfaceConfig   <= image[SLOT_IF_CFG];
      offsetComp.enable <= image[SLOT_HIGH][gyn_pkg::OFF_EN_BIT];
      offsetComp.z      <= {image[SLOT_HIGH][gyn_pkg::OFF_Z_HI_LSB +: 2], image[SLOT_Z_LOW]};
      offsetComp.y      <= {image[SLOT_HIGH][gyn_pkg::OFF_Y_HI_LSB +: 2], image[SLOT_Y_LOW]};
      offsetComp.x      <= {image[SLOT_HIGH][gyn_pkg::OFF_X_HI_LSB +: 2], image[SLOT_X_LOW]};
    end
  end

endmodule : gyn_nvm_image

// ### gyn_pkg.sv
package gyn_pkg;

  // Register offsets on the serial register interface
  localparam logic [7:0] ADDR_STATUS      = 8'h1b;
  localparam logic [7:0] ADDR_MISC_CONFIG = 8'h6a;
  localparam logic [7:0] ADDR_NV_IF_CFG   = 8'h70;
  localparam logic [7:0] ADDR_OFF_X_LOW   = 8'h74;
  localparam logic [7:0] ADDR_OFF_Y_LOW   = 8'h75;
  localparam logic [7:0] ADDR_OFF_Z_LOW   = 8'h76;
  localparam logic [7:0] ADDR_OFF_HIGH_EN = 8'h77;
  localparam logic [7:0] ADDR_COMMAND     = 8'h7e;

  // Command codes
  localparam logic [7:0] CMD_SUSPEND  = 8'h10;
  localparam logic [7:0] CMD_NORMAL   = 8'h11;
  localparam logic [7:0] CMD_PROGRAM  = 8'ha0;

  // Field positions
  localparam int STATUS_NVM_READY_BIT = 4;
  localparam int MISC_PROG_UNLOCK_BIT = 1;
  localparam int OFF_EN_BIT           = 7;
  localparam int OFF_Z_HI_LSB         = 4;
  localparam int OFF_Y_HI_LSB         = 2;
  localparam int OFF_X_HI_LSB         = 0;

  // Writable bit masks; reserved bits read as zero
  localparam logic [7:0] MASK_NV_IF_CFG   = 8'h07;
  localparam logic [7:0] MASK_MISC_CONFIG = 8'h02;
  localparam logic [7:0] MASK_OFF_LOW     = 8'hff;
  localparam logic [7:0] MASK_OFF_HIGH_EN = 8'hbf;

  // Reset values
  localparam logic [7:0] RESET_IMAGE       = 8'h00;
  localparam logic [7:0] RESET_MISC_CONFIG = 8'h00;
  localparam logic [7:0] RESET_READ_DATA   = 8'h00;

  // Image slots: interface config plus four offset bytes
  localparam int IMAGE_COUNT = 5;
  localparam int IMAGE_IDX_W = 3;

  // Timing
  localparam int CLOCK_MHZ          = 50;
  localparam int PROGRAM_TIME_US    = 10000;
  localparam int PROGRAM_CYCLES     = PROGRAM_TIME_US * CLOCK_MHZ;
  localparam int PROG_COUNT_W       = 20;

  // One register access from the serial interface decoder
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } gyn_req_type;

  // Offset compensation image as seen by the datapath
  typedef struct packed {
    logic       enable;
    logic [9:0] z;
    logic [9:0] y;
    logic [9:0] x;
  } gyn_offset_type;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_IDLE,
    ST_PROGRAM
  } gyn_state_type;

endpackage : gyn_pkg

// ### gyn_host_model.sv
`timescale 1ns/10ps
// Host on the register interface; one access at a time
module gyn_host_model (
  input  wire logic           clk,
  input  wire logic [7:0]     readData,
  output gyn_pkg::gyn_req_type request
);
  initial request = '{1'b0, 1'b0, 8'h00, 8'h00};

  // Strobe for one edge, then junk on addr and data so stale values never help
  task acc(input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 request = '{r, !r, a, d};
    @(posedge clk);
    #1 request = '{1'b0, 1'b0, ~a, ~d};
  endtask : acc

  task rd(input logic [7:0] a, output logic [7:0] v);
    acc(1'b1, a, 8'h00);
    v = readData;
  endtask : rd
endmodule : gyn_host_model

// ### gyn_nvm_image_asserts.sv
`timescale 1ns/10ps
module gyn_nvm_image_asserts #(
  parameter int PROGRAM_CYCLES = gyn_pkg::PROGRAM_CYCLES
) (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire gyn_pkg::gyn_req_type    request,
  input wire logic [7:0]              readData,
  input wire logic                    nvmReady,
  input wire logic                    powerNormal,
  input wire logic [7:0]              interfaceConfig,
  input wire gyn_pkg::gyn_offset_type offsetComp
);
  logic unlocked;
  int   busyCnt;
  logic cmdWr;
  logic stRd;

  // Command and status decodes
  assign cmdWr = request.wr && request.addr == gyn_pkg::ADDR_COMMAND;
  assign stRd = request.rd && request.addr == gyn_pkg::ADDR_STATUS;

  // Shadow of the unlock bit, which the ports do not show
  always_ff @(posedge clk)
    if (rst)
      unlocked <= 1'b0;
    else if (request.wr && request.addr == gyn_pkg::ADDR_MISC_CONFIG)
      unlocked <= request.wdata[gyn_pkg::MISC_PROG_UNLOCK_BIT];

  // Length of the current busy spell
  always_ff @(posedge clk)
    if (rst || nvmReady)
      busyCnt <= 0;
    else
      busyCnt <= busyCnt + 1;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence progCmd;
    cmdWr && request.wdata == gyn_pkg::CMD_PROGRAM && nvmReady;
  endsequence
  sequence busyRun;
    !nvmReady [*8];
  endsequence

  load_ready_a: assert property ($fell(rst) |-> !nvmReady ##[1:10] nvmReady)
    else $error("ready wrong after reset");
  prog_start_a: assert property (progCmd ##0 (unlocked && powerNormal) |=> busyRun)
    else $error("program did not start");
  prog_locked_a: assert property (progCmd ##0 !unlocked |=> nvmReady)
    else $error("locked program started");
  prog_suspend_a: assert property (progCmd ##0 !powerNormal |=> nvmReady)
    else $error("program started in suspend");
  prog_bound_a: assert property (busyCnt <= PROGRAM_CYCLES + 8)
    else $error("busy too long");
  status_read_a: assert property (stRd |=> readData == {3'h0, $past(nvmReady), 4'h0})
    else $error("status read wrong");
  image_rw_a: assert property (request.wr && request.addr == 8'h70 && nvmReady
    |=> ##1 interfaceConfig == ($past(request.wdata, 2) & 8'h07)) else $error("image lost");
  power_normal_a: assert property (cmdWr && request.wdata == 8'h11 && nvmReady
    |=> powerNormal) else $error("no normal power");
  power_down_a: assert property (cmdWr && request.wdata == 8'h10 && nvmReady
    |=> !powerNormal) else $error("no suspend");
endmodule : gyn_nvm_image_asserts

bind gyn_nvm_image gyn_nvm_image_asserts #(.PROGRAM_CYCLES(PROGRAM_CYCLES))
  gyn_nvm_image_asserts_inst (.clk(clk), .rst(rst), .request(request), .readData(readData),
  .nvmReady(nvmReady), .powerNormal(powerNormal), .interfaceConfig(interfaceConfig),
  .offsetComp(offsetComp));

// ### test_gyn_nvm_image.sv
`timescale 1ns/10ps
module test_gyn_nvm_image;
  logic                    clk;
  logic                    rst;
  gyn_pkg::gyn_req_type    request;
  logic [7:0]              readData;
  logic                    nvmReady;
  logic                    powerNormal;
  logic [7:0]              interfaceConfig;
  gyn_pkg::gyn_offset_type offsetComp;
  int                      badCount = 0;
  int                      numChecks = 0;
  int                      cycles = 0;
  int                      n;
  logic [7:0]              v;
  logic [7:0]              ad [5] = '{8'h70, 8'h74, 8'h75, 8'h76, 8'h77};
  logic [7:0]              wv [5] = '{8'h05, 8'ha5, 8'h5a, 8'hc3, 8'hb6};
  logic [7:0]              mk [5] = '{8'h07, 8'hff, 8'hff, 8'hff, 8'hbf};

  gyn_host_model gyn_host_model_inst (.clk(clk), .readData(readData), .request(request));
  gyn_nvm_image #(.PROGRAM_CYCLES(20)) gyn_nvm_image_inst (.clk(clk), .rst(rst),
    .request(request), .readData(readData), .nvmReady(nvmReady),
    .powerNormal(powerNormal), .interfaceConfig(interfaceConfig), .offsetComp(offsetComp));

  // 50 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task testDone;
    $display("checks %0d errors %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : testDone

  task chkReg(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR %0t byte %h not %h", $time, got, exp);
    end
  endtask : chkReg

  task chkFlag(input logic got, input logic exp);
    numChecks++;
    if (got !== exp)
    begin
      badCount++;
      $display("ERROR %0t flag %b not %b", $time, got, exp);
    end
  endtask : chkFlag

  task wr(input logic [7:0] a, input logic [7:0] d);
    gyn_host_model_inst.acc(1'b0, a, d);
  endtask : wr

  task rdChk(input logic [7:0] a, input logic [7:0] exp);
    gyn_host_model_inst.rd(a, v);
    chkReg(v, exp);
  endtask : rdChk

  // Poll ready, bounded; n gives the cycles waited
  task waitReady;
    n = 0;
    while (nvmReady !== 1'b1 && n < 100)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : waitReady

  // Cut a hang short; the run needs roughly 120 cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      badCount++;
      testDone;
    end
  end

  initial
  begin
    rst = 1'b1;
    repeat (10) @(posedge clk);
    #1 chkFlag(nvmReady, 1'b0);
    rst = 1'b0;
    @(posedge clk);
    #1 chkFlag(nvmReady, 1'b0);
    waitReady;
    chkFlag(nvmReady, 1'b1);
    rdChk(gyn_pkg::ADDR_STATUS, 8'h10);
    rdChk(8'h00, 8'h00);
    rdChk(gyn_pkg::ADDR_MISC_CONFIG, 8'h00);
    // Zero store loaded; then write every image back to back
    for (int i = 0; i < 5; i++)
      rdChk(ad[i], 8'h00);
    for (int i = 0; i < 5; i++)
      wr(ad[i], wv[i]);
    for (int i = 0; i < 5; i++)
      rdChk(ad[i], wv[i] & mk[i]);
    chkReg(interfaceConfig, 8'h05);
    chkReg(offsetComp.z[7:0], 8'hc3);
    chkReg(offsetComp.x[7:0], 8'ha5);
    chkReg({offsetComp.x[9:8], offsetComp.y[9:8], offsetComp.z[9:8], 2'b00}, 8'h9c);
    chkFlag(offsetComp.enable, 1'b1);
    // Refused programs: still locked, then unlocked but in suspend
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_NORMAL);
    chkFlag(powerNormal, 1'b1);
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_PROGRAM);
    chkFlag(nvmReady, 1'b1);
    wr(gyn_pkg::ADDR_MISC_CONFIG, 8'h02);
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_SUSPEND);
    chkFlag(powerNormal, 1'b0);
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_PROGRAM);
    chkFlag(nvmReady, 1'b1);
    // Real program, then wipe images and reset to reload the store
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_NORMAL);
    wr(gyn_pkg::ADDR_COMMAND, gyn_pkg::CMD_PROGRAM);
    chkFlag(nvmReady, 1'b0);
    rdChk(gyn_pkg::ADDR_STATUS, 8'h00);
    waitReady;
    chkFlag(n inside {[15:22]}, 1'b1);
    for (int i = 0; i < 5; i++)
      wr(ad[i], 8'h00);
    rdChk(ad[4], 8'h00);
    @(posedge clk);
    #1 rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    waitReady;
    for (int i = 0; i < 5; i++)
      rdChk(ad[i], wv[i] & mk[i]);
    testDone;
  end
endmodule : test_gyn_nvm_image
